// ==== design/ihc_pkg.sv ====
// Shared constants for the interrupt and halt controller
package ihc_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 4;
   localparam logic [6:0] ADDR_PIN_MASK = 7'h75;
   localparam logic [6:0] ADDR_SW_MASK = 7'h76;
   localparam logic [6:0] ADDR_CT_MASK = 7'h78;
   localparam logic [6:0] ADDR_CT_FLAG = 7'h79;
   localparam logic [6:0] ADDR_PS_FLAG = 7'h7A;
   localparam int BIT_CT_SLOW = 2;
   localparam int BIT_CT_MID = 1;
   localparam int BIT_CT_FAST = 0;
   localparam int BIT_SW_SECOND = 1;
   localparam int BIT_SW_TENTH = 0;
   localparam int BIT_PIN_EDGE = 2;
   localparam int BIT_MODE = 3;
   localparam logic [3:0] RESET_NIBBLE = 4'h0;
   localparam logic [3:0] VEC_PAGE = 4'h1;
   localparam int PC_W = 12;
   localparam logic [4:0] ACCEPT_CYCLES = 5'h0C;
   localparam int GRP_PIN = 0;
   localparam int GRP_CT = 1;
   localparam int GRP_SW = 2;
   typedef enum logic [2:0] {
      IHC_RUN = 3'b001,
      IHC_HALT = 3'b010,
      IHC_ACCEPT = 3'b100
   } ihc_state_t;
endpackage

// ==== design/ihc_fall_det.sv ====
// Falling edge detector for a group of event lines
`timescale 1ns/1ps
module ihc_fall_det #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] fall
);
   typedef struct packed {
      logic [WIDTH-1:0] last;
   } ihc_fd_t;
   ihc_fd_t r;
   ihc_fd_t next_r;

   always_comb begin
      next_r = r;
      next_r.last = level;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign fall = r.last & ~level;
endmodule

// ==== design/ihc_reset_sync.sv ====
// Reset release synchroniser
`timescale 1ns/1ps
module ihc_reset_sync (
   input wire logic clock,
   input wire logic arst_n,
   output logic rst_n
);
   typedef struct packed {
      logic s1;
      logic s2;
   } ihc_rs_t;
   ihc_rs_t r;
   ihc_rs_t next_r;

   always_comb begin
      next_r = r;
      next_r.s1 = 1'b1;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rst_n = r.s2;
endmodule

// ==== design/ihc_irq_halt_ctrl.sv ====
// Interrupt factor flags, masks, vector select and halt control
// Operation
// - Service interrupts only with interrupt-enable set and mask bit 1; a pin flag set before its mask is cleared still requests.
// - Acceptance clears the interrupt-enable flag automatically.
// - Halt stops the CPU; oscillator and peripherals keep running.
// - Only an interrupt leaves halt; return goes past the halt instruction.
// - Factor flags set on their event regardless of interrupt-enable.
// - Request when flag, mask and interrupt-enable are all 1.
// - Flags are read-only, cleared right after read; writes ignored.
// - Reset clears all flags and mask bits.
// - Timer 2, 8, 32 Hz falling edges set flag bits 2, 1, 0.
// - Stopwatch 1 Hz and 10 Hz falling edges set bits 1 and 0.
// - Falling edge on any unmasked input pin sets shared pin flag bit 2.
// - Mask bits read/write; 1 enables, 0 masks; timer and stopwatch flags still record, masked pins set no flag.
// - Timer masks at bits 2..0; stopwatch masks at bits 1..0.
// - Acceptance pushes next address then jumps to page 1 vector.
// - Save and vector load take exactly twelve CPU clocks.
// - Vector step is twice the 3-bit group set: pin, timer, stopwatch.
// - Unused bits read 0 and hold no storage.
// - Software may re-enable interrupts in a handler for nesting.
// - Mode bit 3: heavy load at stopwatch mask, static LCD at timer mask.
`timescale 1ns/1ps
module ihc_irq_halt_ctrl #(
   parameter int PIN_N = 4
) (
   input wire logic clock,
   input wire logic arst_n,
   // CPU I/O memory port
   input wire logic [ihc_pkg::ADDR_W-1:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [ihc_pkg::DATA_W-1:0] io_wdata,
   output logic [ihc_pkg::DATA_W-1:0] io_rdata,
   output logic io_hit,
   // CPU core control
   input wire logic ei_set,
   input wire logic di_set,
   input wire logic halt_exec,
   input wire logic instr_boundary,
   input wire logic [ihc_pkg::PC_W-1:0] next_pc,
   output logic irq_enabled_state,
   output logic cpu_halted,
   output logic cpu_stall,
   output logic push_pc,
   output logic [ihc_pkg::PC_W-1:0] push_addr,
   output logic load_pc,
   output logic [ihc_pkg::PC_W-1:0] vector_pc,
   // Peripheral event sources
   input wire logic ct_2hz,
   input wire logic ct_8hz,
   input wire logic ct_32hz,
   input wire logic sw_1hz,
   input wire logic sw_10hz,
   input wire logic [PIN_N-1:0] input_pins,
   // Mode outputs
   output logic heavy_load_select,
   output logic lcd_static_select
);
   typedef struct packed {
      ihc_pkg::ihc_state_t state;
      logic [4:0] cnt;
      logic ie;
      logic [2:0] grp;
      logic [ihc_pkg::PC_W-1:0] ret_pc;
      logic [PIN_N-1:0] pin_mask;
      logic [1:0] sw_mask;
      logic heavy;
      logic [2:0] ct_mask;
      logic lcd_static;
      logic [2:0] ct_flag;
      logic [2:0] ps_flag;
      logic [ihc_pkg::DATA_W-1:0] rdata;
      logic hit;
   } ihc_regs_t;

   ihc_regs_t r;
   ihc_regs_t next_r;
   logic rst_n;
   logic [2:0] ct_fall;
   logic [1:0] sw_fall;
   logic [PIN_N-1:0] pin_fall;
   logic [2:0] ct_ev;
   logic [2:0] ps_ev;
   logic [2:0] grp_req;
   logic any_req;

   ihc_reset_sync u_rst (
      .clock(clock),
      .arst_n(arst_n),
      .rst_n(rst_n)
   );

   // Peripherals keep running in halt, so edges are always watched
   ihc_fall_det #(.WIDTH(3)) u_ct_fall (
      .clock(clock),
      .rst_n(rst_n),
      .level({ct_2hz, ct_8hz, ct_32hz}),
      .fall(ct_fall)
   );

   ihc_fall_det #(.WIDTH(2)) u_sw_fall (
      .clock(clock),
      .rst_n(rst_n),
      .level({sw_1hz, sw_10hz}),
      .fall(sw_fall)
   );

   ihc_fall_det #(.WIDTH(PIN_N)) u_pin_fall (
      .clock(clock),
      .rst_n(rst_n),
      .level(input_pins),
      .fall(pin_fall)
   );

   always_comb begin
      ct_ev = '0;
      ct_ev[ihc_pkg::BIT_CT_SLOW] = ct_fall[2];
      ct_ev[ihc_pkg::BIT_CT_MID] = ct_fall[1];
      ct_ev[ihc_pkg::BIT_CT_FAST] = ct_fall[0];
      ps_ev = '0;
      ps_ev[ihc_pkg::BIT_SW_SECOND] = sw_fall[1];
      ps_ev[ihc_pkg::BIT_SW_TENTH] = sw_fall[0];
      ps_ev[ihc_pkg::BIT_PIN_EDGE] = |(pin_fall & r.pin_mask);
   end

   // Per-group OR of flag and mask products for timer and stopwatch; pin group is its flag alone
   always_comb begin
      grp_req = '0;
      grp_req[ihc_pkg::GRP_PIN] = r.ps_flag[ihc_pkg::BIT_PIN_EDGE];
      grp_req[ihc_pkg::GRP_CT] = |(r.ct_flag & r.ct_mask);
      grp_req[ihc_pkg::GRP_SW] = |(r.ps_flag[1:0] & r.sw_mask);
      any_req = r.ie && (|grp_req);
   end

   always_comb begin
      next_r = r;
      next_r.hit = 1'b0;
      next_r.rdata = ihc_pkg::RESET_NIBBLE;

      // Register read; unused bits are constant zero
      if (io_rd) begin
         next_r.hit = 1'b1;
         case (io_addr)
            ihc_pkg::ADDR_PIN_MASK: next_r.rdata = r.pin_mask;
            ihc_pkg::ADDR_SW_MASK: next_r.rdata = {r.heavy, 1'b0, r.sw_mask};
            ihc_pkg::ADDR_CT_MASK: next_r.rdata = {r.lcd_static, r.ct_mask};
            ihc_pkg::ADDR_CT_FLAG: next_r.rdata = {1'b0, r.ct_flag};
            ihc_pkg::ADDR_PS_FLAG: next_r.rdata = {1'b0, r.ps_flag};
            default: next_r.hit = 1'b0;
         endcase
      end

      // Read clears the flags; an event in the same cycle survives
      if (io_rd && io_addr == ihc_pkg::ADDR_CT_FLAG) begin
         next_r.ct_flag = '0;
      end
      if (io_rd && io_addr == ihc_pkg::ADDR_PS_FLAG) begin
         next_r.ps_flag = '0;
      end
      next_r.ct_flag = next_r.ct_flag | ct_ev;
      next_r.ps_flag = next_r.ps_flag | ps_ev;

      // Mask writes; flag addresses ignore writes
      if (io_wr) begin
         case (io_addr)
            ihc_pkg::ADDR_PIN_MASK: next_r.pin_mask = io_wdata[PIN_N-1:0];
            ihc_pkg::ADDR_SW_MASK: begin
               next_r.sw_mask = io_wdata[1:0];
               next_r.heavy = io_wdata[ihc_pkg::BIT_MODE];
            end
            ihc_pkg::ADDR_CT_MASK: begin
               next_r.ct_mask = io_wdata[2:0];
               next_r.lcd_static = io_wdata[ihc_pkg::BIT_MODE];
            end
            default: begin
            end
         endcase
      end

      // Software enable; nesting allowed from inside a handler
      if (ei_set) begin
         next_r.ie = 1'b1;
      end else if (di_set) begin
         next_r.ie = 1'b0;
      end

      case (r.state)
         ihc_pkg::IHC_RUN: begin
            if (any_req && instr_boundary) begin
               next_r.state = ihc_pkg::IHC_ACCEPT;
               next_r.grp = grp_req;
               next_r.ret_pc = next_pc;
               next_r.ie = 1'b0;
               next_r.cnt = 5'h01;
            end else if (halt_exec) begin
               next_r.state = ihc_pkg::IHC_HALT;
            end
         end
         ihc_pkg::IHC_HALT: begin
            // next_pc already points past the halt instruction
            if (any_req) begin
               next_r.state = ihc_pkg::IHC_ACCEPT;
               next_r.grp = grp_req;
               next_r.ret_pc = next_pc;
               next_r.ie = 1'b0;
               next_r.cnt = 5'h01;
            end
         end
         ihc_pkg::IHC_ACCEPT: begin
            if (r.cnt == ihc_pkg::ACCEPT_CYCLES) begin
               next_r.state = ihc_pkg::IHC_RUN;
               next_r.cnt = '0;
            end else begin
               next_r.cnt = r.cnt + 5'h01;
            end
         end
         default: begin
            next_r.state = ihc_pkg::IHC_RUN;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{state: ihc_pkg::IHC_RUN, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign io_rdata = r.rdata;
   assign io_hit = r.hit;
   assign irq_enabled_state = r.ie;
   assign cpu_halted = (r.state == ihc_pkg::IHC_HALT);
   assign cpu_stall = (r.state != ihc_pkg::IHC_RUN);
   assign push_pc = (r.state == ihc_pkg::IHC_ACCEPT) && (r.cnt == 5'h01);
   assign push_addr = r.ret_pc;
   assign load_pc = (r.state == ihc_pkg::IHC_ACCEPT) && (r.cnt == ihc_pkg::ACCEPT_CYCLES);
   // Step is twice the group set, so bit 0 is always clear
   assign vector_pc = {ihc_pkg::VEC_PAGE, 4'h0, r.grp, 1'b0};
   assign heavy_load_select = r.heavy;
   assign lcd_static_select = r.lcd_static;
endmodule

// ==== testbench/ihc_monitor.sv ====
// Port-level assertions for the interrupt and halt controller
`timescale 1ns/1ps
module ihc_monitor #(
   parameter int PIN_N = 4
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [6:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [3:0] io_wdata,
   input wire logic [3:0] io_rdata,
   input wire logic io_hit,
   input wire logic ei_set,
   input wire logic halt_exec,
   input wire logic irq_enabled_state,
   input wire logic cpu_halted,
   input wire logic cpu_stall,
   input wire logic push_pc,
   input wire logic load_pc,
   input wire logic [11:0] vector_pc,
   input wire logic heavy_load_select
);
   logic mapped;
   assign mapped = io_addr inside {7'h75, 7'h76, 7'h78, 7'h79, 7'h7A};
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence accept_s;
      !irq_enabled_state && cpu_stall ##11 load_pc ##1 !cpu_stall;
   endsequence
   accept_len_a: assert property (push_pc |-> accept_s) else $error("bad acceptance");
   vec_page_a: assert property (load_pc |-> vector_pc[11:4] == 8'h10 && !vector_pc[0] && vector_pc[3:1] != 3'h0)
      else $error("bad vector");
   no_irq_off_a: assert property (!irq_enabled_state |=> !push_pc) else $error("taken while disabled");
   read_hit_a: assert property (io_rd && mapped |=> io_hit) else $error("mapped read missed");
   unmapped_a: assert property (io_rd && !mapped |=> !io_hit && io_rdata == 4'h0) else $error("unmapped hit");
   flag_msb_a: assert property (io_rd && io_addr inside {7'h79, 7'h7A} |=> !io_rdata[3])
      else $error("bit 3 set");
   halt_enter_a: assert property (halt_exec && !irq_enabled_state |=> cpu_halted) else $error("no halt");
   wake_up_a: assert property (load_pc |=> !cpu_halted) else $error("still halted");
   ei_take_a: assert property (ei_set |=> irq_enabled_state) else $error("enable lost");
   heavy_mode_a: assert property (io_wr && io_addr == 7'h76 && io_wdata[3] |=> heavy_load_select)
      else $error("mode bit lost");
endmodule

bind ihc_irq_halt_ctrl ihc_monitor #(.PIN_N(PIN_N)) i_ihc_monitor (.*);

// ==== testbench/ihc_cpu_model.sv ====
// Behavioural CPU core facing the controller
`timescale 1ns/1ps
module ihc_cpu_model (
   input wire logic clock,
   input wire logic cpu_stall,
   output logic instr_boundary,
   output logic [11:0] next_pc
);
   logic phase = 1'b0;
   initial next_pc = 12'h200;
   // Two-clock instructions, so requests wait for a boundary
   assign instr_boundary = phase;
   always @(posedge clock) begin
      // Frozen while halted or saving, so return follows the halt
      if (!cpu_stall) begin
         phase <= ~phase;
         next_pc <= next_pc + {11'h000, phase};
      end
   end
endmodule

// ==== testbench/irq_halt_controller_tb.sv ====
// Self-checking bench for the interrupt and halt controller
`timescale 1ns/1ps
module irq_halt_controller_tb;
   logic clock = 1'b0, arst_n = 1'b0, io_rd = 1'b0, io_wr = 1'b0, ei_set = 1'b0, di_set = 1'b0;
   logic halt_exec = 1'b0, ct_2hz = 1'b1, ct_8hz = 1'b1, ct_32hz = 1'b1, sw_1hz = 1'b1, sw_10hz = 1'b1;
   logic [6:0] io_addr = 7'h00;
   logic [3:0] io_wdata = 4'h0, input_pins = 4'hF, io_rdata, r, q;
   logic io_hit, instr_boundary, irq_enabled_state, cpu_halted, cpu_stall, push_pc, load_pc;
   logic heavy_load_select, lcd_static_select, rd_d = 1'b0;
   logic [11:0] next_pc, push_addr, vector_pc;
   logic [4:0] e, rq[$];
   logic [23:0] vq[$];
   int miscompares = 0, checked = 0, n;
   always #25 clock = ~clock;
   ihc_irq_halt_ctrl #(.PIN_N(4)) i_ihc_irq_halt_ctrl (.*);
   ihc_cpu_model i_ihc_cpu_model (.*);
   task automatic tally_and_finish;
      if (rq.size() + vq.size() != 0) miscompares++;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp_reg(logic [4:0] x, logic [4:0] y);
      checked++;
      if (y !== x) begin
         miscompares++;
         $display("CHECK FAILED hit_and_rdata expected %h seen %h", x, y);
      end
   endtask
   task automatic cmp_vec(logic [23:0] x, logic [23:0] y);
      checked++;
      if (y !== x) begin
         miscompares++;
         $display("CHECK FAILED push_and_vector expected %h seen %h", x, y);
      end
   endtask
   task automatic wr(logic [6:0] a, logic [3:0] d);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clock);
      io_wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(logic [6:0] a, logic [4:0] x);
      rq.push_back(x);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clock);
      io_rd <= 1'b0;
      @(posedge clock);
   endtask
   task automatic fire(logic [4:0] ev, logic [3:0] p);
      {ct_2hz, ct_8hz, ct_32hz, sw_1hz, sw_10hz} <= ~ev;
      input_pins <= ~p;
      @(posedge clock);
      {ct_2hz, ct_8hz, ct_32hz, sw_1hz, sw_10hz} <= 5'h1F;
      input_pins <= 4'hF;
      repeat (3) @(posedge clock);
   endtask
   always @(posedge clock) begin
      rd_d <= io_rd;
      if (rd_d) cmp_reg(rq.pop_front(), {io_hit, io_rdata});
      if (load_pc) cmp_vec(vq.pop_front(), {push_addr, vector_pc});
   end
   initial begin
      void'($urandom(36));
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      // Offset 2 of this run is the unmapped hole between the masks
      foreach (q[i]) rd(7'h75 + 7'(i), (i == 2) ? 5'h00 : 5'h10);
      rd(7'h79, 5'h10);
      rd(7'h7A, 5'h10);
      rd(7'h77, 5'h00);
      repeat (4) begin
         r = 4'($urandom);
         wr(7'h75, r);
         wr(7'h76, r);
         wr(7'h78, r);
         wr(7'h79, r);
         rd(7'h75, {1'b1, r});
         rd(7'h76, {1'b1, r & 4'hB});
         rd(7'h78, {1'b1, r});
         rd(7'h79, 5'h10);
      end
      for (n = 0; n < 6; n++) begin
         r = (n == 0) ? 4'h0 : 4'($urandom);
         q = 4'($urandom);
         e = 5'($urandom);
         wr(7'h75, r);
         fire(e, q);
         rd(7'h79, {2'b10, e[4:2]});
         rd(7'h7A, {2'b10, |(r & q), e[1:0]});
         rd(7'h79, 5'h10);
      end
      wr(7'h75, 4'hF);
      wr(7'h76, 4'h3);
      wr(7'h78, 4'h7);
      for (int g = 1; g < 8; g++) begin
         halt_exec <= 1'b1;
         @(posedge clock);
         halt_exec <= 1'b0;
         fire({{3{g[1]}}, {2{g[2]}}}, {4{g[0]}});
         vq.push_back({next_pc, 8'h10, 3'(g), 1'b0});
         ei_set <= 1'b1;
         @(posedge clock);
         ei_set <= 1'b0;
         for (n = 0; n < 40 && (cpu_halted || cpu_stall); n++) @(posedge clock);
         if (n == 40) begin
            miscompares++;
            tally_and_finish();
         end
         rd(7'h79, {2'b10, {3{g[1]}}});
         rd(7'h7A, {2'b10, g[0], {2{g[2]}}});
      end
      repeat (3) @(posedge clock);
      tally_and_finish();
   end
endmodule
